/* File: sysconf_pkg.sv */
// register offsets, field positions, reset values and timing figures
// for the system configuration, watchdog and refresh register bank.
// assumes a 16-bit word register port driven by the processor core.
package sysconf_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_REFRESH_BASE = 8'hE0;
  localparam logic [7:0] OFS_REFRESH_INTERVAL = 8'hE2;
  localparam logic [7:0] OFS_REFRESH_CONTROL = 8'hE4;
  localparam logic [7:0] OFS_WATCHDOG_CONTROL = 8'hE6;
  localparam logic [7:0] OFS_SYSTEM_CONFIG = 8'hF0;
  localparam logic [7:0] OFS_AUX_CONFIG = 8'hF2;
  localparam logic [7:0] OFS_RELEASE_LEVEL = 8'hF4;
  localparam logic [7:0] OFS_RESET_LATCH = 8'hF6;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] RST_SYSTEM_CONFIG = 16'h0000;
  localparam logic [15:0] RST_AUX_CONFIG = 16'h0000;
  localparam logic [15:0] RST_WATCHDOG_CONTROL = 16'hC080;
  localparam logic [15:0] RST_REFRESH_CONTROL = 16'h0000;
  localparam logic [15:0] RST_REFRESH_BASE = 16'h0000;
  localparam logic [15:0] RST_REFRESH_INTERVAL = 16'h0000;

  // ------------------------------------------------------------------
  // auxiliary configuration fields
  // ------------------------------------------------------------------
  localparam int AUX_PORT1_CTS = 6;
  localparam int AUX_PORT1_READY = 5;
  localparam int AUX_PORT0_CTS = 4;
  localparam int AUX_PORT0_READY = 3;
  localparam int AUX_LOWER_BYTE = 2;
  localparam int AUX_MIDDLE_BYTE = 1;
  localparam int AUX_IO_BYTE = 0;
  localparam logic [15:0] AUX_WRITE_MASK = 16'h007F;

  // ------------------------------------------------------------------
  // system configuration fields
  // ------------------------------------------------------------------
  localparam int SYS_POWER_SAVE = 15;
  localparam int SYS_WHOLE_MIDDLE = 14;
  localparam int SYS_STROBE_SELECT = 13;
  localparam int SYS_DEMOD_ENABLE = 12;
  localparam int SYS_CLKB_SOURCE = 11;
  localparam int SYS_CLKB_DISABLE = 10;
  localparam int SYS_CLKA_SOURCE = 9;
  localparam int SYS_CLKA_DISABLE = 8;
  localparam int SYS_DIV_LSB = 0;
  localparam int SYS_DIV_WIDTH = 3;
  localparam logic [15:0] SYS_WRITE_MASK = 16'hFF07;

  // ------------------------------------------------------------------
  // watchdog control fields
  // ------------------------------------------------------------------
  localparam int WDT_ENABLE = 15;
  localparam int WDT_RESET_SELECT = 14;
  localparam int WDT_RESET_FLAG = 13;
  localparam int WDT_NMI_FLAG = 12;
  localparam int WDT_TEST = 11;
  localparam int WDT_COUNT_LSB = 0;
  localparam int WDT_COUNT_WIDTH = 8;
  localparam logic [15:0] WDT_READ_MASK = 16'hF8FF;
  localparam logic [4:0] WDT_EXP_BIT0 = 5'd10;
  localparam logic [4:0] WDT_EXP_BIT1 = 5'd20;
  localparam int WDT_CNT_WIDTH = 27;

  // ------------------------------------------------------------------
  // refresh fields
  // ------------------------------------------------------------------
  localparam int RFSH_ENABLE = 15;
  localparam int RFSH_CNT_WIDTH = 9;
  localparam int RFSH_BASE_LSB = 9;
  localparam int RFSH_BASE_WIDTH = 7;
  localparam int RFSH_ROW_WIDTH = 13;
  localparam int RELEASE_LSB = 8;

endpackage

/* File: sysconf_regs.sv */
// system configuration, watchdog and refresh register bank.
// assumes the core register port and interrupt inputs are on clock;
// the address/data pins come from outside and are synchronised here.
//
// How it works
// RL1 - pin word sampled at reset release, read-only until next reset
// RL2 - release register returns code in bits 15-8, low byte zero
// RL3 - aux register holds two flow-control pin selects per port
// RL4 - lower space width bit chooses byte or word accesses
// RL5 - middle space width bit, also peripheral space when memory mapped
// RL6 - io width bit chooses byte or word io accesses
// RL7 - power save divides clock; hardware interrupt clears it
// RL8 - software interrupts and interrupt return leave power save alone
// RL9 - divider is two to field power, active only in power save
// RL10 - whole range middle select frees second and third selects
// RL11 - strobe select bit picks data strobe or data enable
// RL12 - demodulator enable bit switches the pulse width demodulator
// RL13 - clock outputs choose crystal or divided clock, or forced low
// RL14 - watchdog enable runs the watchdog; control resets to c080h
// RL15 - timeout resets if reset select or nmi flag, else nmi
// RL16 - timeout reset flag set on reset timeout, cleared by software
// RL17 - nmi flag set on nmi event, cleared by software
// RL18 - timeout is two to exponent from lowest set count bit
// RL19 - refresh enable runs counter, clearing stops it, keeps address
// RL20 - refresh control shows nine-bit counter, bits 14-9 zero
// RL21 - interval register nine bits, upper bits read zero
// RL22 - base register holds address bits 19-13, low bits zero
// RL23 - counter runs to interval, requests once, restarts from zero
`timescale 1ns/1ps
`default_nettype none

module sysconf_regs
  import sysconf_pkg::*;
#(
  // raised in simulation to shorten watchdog timeouts
  parameter int TIMEOUT_EXP_REDUCE = 0,
  // arbitrary neutral release code
  parameter logic [7:0] RELEASE_CODE = 8'h5A
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port from the core
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // address/data pins, sampled at reset release
  input wire logic [15:0] ad_pins,
  // interrupt sources
  input wire logic hw_interrupt,
  input wire logic sw_interrupt,
  input wire logic interrupt_return,
  // serial flow-control pin roles
  output logic port1_cts_select,
  output logic port1_ready_select,
  output logic port0_cts_select,
  output logic port0_ready_select,
  // bus width per space
  output logic lower_space_byte_width,
  output logic middle_space_byte_width,
  output logic io_space_byte_width,
  // clock and power
  output logic power_save_enable,
  output logic [2:0] clock_divider_field,
  output logic internal_clock_tick,
  output logic clock_out_a_source,
  output logic clock_out_a_disable,
  output logic clock_out_b_source,
  output logic clock_out_b_disable,
  // pin functions
  output logic whole_range_middle_select,
  output logic strobe_select,
  output logic demodulator_enable,
  // watchdog
  output logic watchdog_reset,
  output logic watchdog_nmi,
  // refresh
  output logic refresh_strobe_mode,
  output logic refresh_request,
  output logic [19:0] refresh_address
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [4:0] wdt_exponent(input logic [7:0] cnt);
    logic [4:0] e;
    e = 5'd0;
    if (cnt[0]) begin
      e = WDT_EXP_BIT0;
    end else begin
      for (int i = 7; i >= 1; i--) begin
        if (cnt[i]) begin
          e = WDT_EXP_BIT1 + 5'(i - 1);
        end
      end
    end
    return e;
  endfunction
  function automatic logic [6:0] div_mask(input logic [2:0] f);
    return 7'((8'h01 << f) - 8'h01);
  endfunction
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [15:0] ad_sync1_r;
  logic [15:0] ad_sync2_r;
  logic reset_pending_r;
  logic [15:0] latched_pin_value_r;
  logic [15:0] aux_r;
  logic [15:0] sys_r;
  logic [15:0] wdt_r;
  logic rfsh_enable_r;
  logic [8:0] rfsh_cnt_r;
  logic [8:0] rfsh_interval_r;
  logic [6:0] rfsh_base_r;
  logic [12:0] rfsh_row_r;
  logic [6:0] div_cnt_r;
  logic tick_r;
  logic [WDT_CNT_WIDTH-1:0] wdt_cnt_r;
  logic wdt_reset_r;
  logic wdt_nmi_r;
  logic rfsh_req_r;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic wr_sys;
  logic wr_aux;
  logic wr_wdt;
  logic wr_rctl;
  logic wr_rint;
  logic wr_rbase;
  logic wdt_timeout;
  logic wdt_to_reset;
  logic [4:0] wdt_exp;
  logic [WDT_CNT_WIDTH-1:0] wdt_limit;
  logic rfsh_hit;
  assign wr_sys = reg_wr && hit(reg_addr, OFS_SYSTEM_CONFIG);
  assign wr_aux = reg_wr && hit(reg_addr, OFS_AUX_CONFIG);
  assign wr_wdt = reg_wr && hit(reg_addr, OFS_WATCHDOG_CONTROL);
  assign wr_rctl = reg_wr && hit(reg_addr, OFS_REFRESH_CONTROL);
  assign wr_rint = reg_wr && hit(reg_addr, OFS_REFRESH_INTERVAL);
  assign wr_rbase = reg_wr && hit(reg_addr, OFS_REFRESH_BASE);

  // ------------------------------------------------------------------
  // reset pin latch
  // ------------------------------------------------------------------
  // pins are asynchronous to clock; no reset so they track during reset
  always_ff @(posedge clock) begin
    ad_sync1_r <= ad_pins;
    ad_sync2_r <= ad_sync1_r;
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reset_pending_r <= 1'b1;
    end else begin
      reset_pending_r <= 1'b0;
    end
  end
  // caught on the first edge after release, held until next reset
  always_ff @(posedge clock) begin
    if (resetn && reset_pending_r) begin
      latched_pin_value_r <= ad_sync2_r; // [RL1]
    end
  end

  // ------------------------------------------------------------------
  // auxiliary configuration
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      aux_r <= RST_AUX_CONFIG; // [RL3]
    end else if (wr_aux) begin
      aux_r <= reg_wdata & AUX_WRITE_MASK; // [RL3]
    end
  end
  assign port1_cts_select = aux_r[AUX_PORT1_CTS]; // [RL3]
  assign port1_ready_select = aux_r[AUX_PORT1_READY]; // [RL3]
  assign port0_cts_select = aux_r[AUX_PORT0_CTS]; // [RL3]
  assign port0_ready_select = aux_r[AUX_PORT0_READY]; // [RL3]
  assign lower_space_byte_width = aux_r[AUX_LOWER_BYTE]; // [RL4]
  // chip-select logic applies this to peripheral space only when mapped
  assign middle_space_byte_width = aux_r[AUX_MIDDLE_BYTE]; // [RL5]
  assign io_space_byte_width = aux_r[AUX_IO_BYTE]; // [RL6]

  // ------------------------------------------------------------------
  // system configuration
  // ------------------------------------------------------------------
  // a hardware interrupt in the same cycle as a write wins, so a wake-up
  // is never lost; software interrupts and returns have no effect
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sys_r <= RST_SYSTEM_CONFIG;
    end else begin
      if (wr_sys) begin
        sys_r <= reg_wdata & SYS_WRITE_MASK;
      end
      if (hw_interrupt) begin
        sys_r[SYS_POWER_SAVE] <= 1'b0; // [RL7] [RL8]
      end
    end
  end
  assign power_save_enable = sys_r[SYS_POWER_SAVE]; // [RL7]
  assign clock_divider_field = sys_r[SYS_DIV_LSB +: SYS_DIV_WIDTH];
  assign whole_range_middle_select = sys_r[SYS_WHOLE_MIDDLE]; // [RL10]
  assign strobe_select = sys_r[SYS_STROBE_SELECT]; // [RL11]
  assign demodulator_enable = sys_r[SYS_DEMOD_ENABLE]; // [RL12]
  assign clock_out_a_source = sys_r[SYS_CLKA_SOURCE]; // [RL13]
  assign clock_out_a_disable = sys_r[SYS_CLKA_DISABLE]; // [RL13]
  assign clock_out_b_source = sys_r[SYS_CLKB_SOURCE]; // [RL13]
  assign clock_out_b_disable = sys_r[SYS_CLKB_DISABLE]; // [RL13]

  // ------------------------------------------------------------------
  // power-save clock divider
  // ------------------------------------------------------------------
  // tick marks one divided clock; high every cycle outside power save
  always_ff @(posedge clock) begin
    if (!resetn || !power_save_enable) begin
      div_cnt_r <= 7'h00;
    end else if ((div_cnt_r & div_mask(clock_divider_field)) ==
                 div_mask(clock_divider_field)) begin
      div_cnt_r <= 7'h00; // [RL9]
    end else begin
      div_cnt_r <= div_cnt_r + 7'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= !power_save_enable ||
                ((div_cnt_r & div_mask(clock_divider_field)) ==
                 div_mask(clock_divider_field)); // [RL9]
    end
  end
  assign internal_clock_tick = tick_r;

  // ------------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------------
  // a zero count has no defined period, so it never times out
  always_comb begin
    wdt_exp = wdt_exponent(wdt_r[WDT_COUNT_LSB +: WDT_COUNT_WIDTH]);
    wdt_limit = '0;
    if (wdt_exp != 5'd0) begin
      wdt_limit = (WDT_CNT_WIDTH'(1) <<
                   (wdt_exp - 5'(TIMEOUT_EXP_REDUCE))) -
                  WDT_CNT_WIDTH'(1); // [RL18]
    end
  end
  assign wdt_timeout = wdt_r[WDT_ENABLE] && (wdt_exp != 5'd0) &&
                       (wdt_cnt_r == wdt_limit); // [RL14] [RL18]
  assign wdt_to_reset = wdt_r[WDT_RESET_SELECT] ||
                        wdt_r[WDT_NMI_FLAG]; // [RL15]
  // any write to the control register restarts the period
  always_ff @(posedge clock) begin
    if (!resetn || !wdt_r[WDT_ENABLE] || wr_wdt || wdt_timeout) begin
      wdt_cnt_r <= '0; // [RL14]
    end else begin
      wdt_cnt_r <= wdt_cnt_r + WDT_CNT_WIDTH'(1);
    end
  end
  // flags clear on writing zero; a timeout in the same cycle wins
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wdt_r <= RST_WATCHDOG_CONTROL; // [RL14]
    end else begin
      if (wr_wdt) begin
        wdt_r[WDT_ENABLE] <= reg_wdata[WDT_ENABLE];
        wdt_r[WDT_RESET_SELECT] <= reg_wdata[WDT_RESET_SELECT];
        wdt_r[WDT_TEST] <= reg_wdata[WDT_TEST];
        wdt_r[WDT_COUNT_LSB +: WDT_COUNT_WIDTH] <=
          reg_wdata[WDT_COUNT_LSB +: WDT_COUNT_WIDTH];
        if (!reg_wdata[WDT_RESET_FLAG]) begin
          wdt_r[WDT_RESET_FLAG] <= 1'b0; // [RL16]
        end
        if (!reg_wdata[WDT_NMI_FLAG]) begin
          wdt_r[WDT_NMI_FLAG] <= 1'b0; // [RL17]
        end
      end
      if (wdt_timeout && wdt_to_reset) begin
        wdt_r[WDT_RESET_FLAG] <= 1'b1; // [RL16]
      end
      if (wdt_timeout && !wdt_to_reset) begin
        wdt_r[WDT_NMI_FLAG] <= 1'b1; // [RL17]
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wdt_reset_r <= 1'b0;
      wdt_nmi_r <= 1'b0;
    end else begin
      wdt_reset_r <= wdt_timeout && wdt_to_reset; // [RL15]
      wdt_nmi_r <= wdt_timeout && !wdt_to_reset; // [RL15]
    end
  end
  assign watchdog_reset = wdt_reset_r;
  assign watchdog_nmi = wdt_nmi_r;

  // ------------------------------------------------------------------
  // refresh
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rfsh_enable_r <= RST_REFRESH_CONTROL[RFSH_ENABLE];
    end else if (wr_rctl) begin
      rfsh_enable_r <= reg_wdata[RFSH_ENABLE]; // [RL19]
    end
  end
  // interval is undefined by design; held at zero to stay deterministic
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rfsh_interval_r <= RST_REFRESH_INTERVAL[RFSH_CNT_WIDTH-1:0];
    end else if (wr_rint) begin
      rfsh_interval_r <= reg_wdata[RFSH_CNT_WIDTH-1:0]; // [RL21]
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rfsh_base_r <= RST_REFRESH_BASE[RFSH_BASE_LSB +: RFSH_BASE_WIDTH];
    end else if (wr_rbase) begin
      rfsh_base_r <= reg_wdata[RFSH_BASE_LSB +: RFSH_BASE_WIDTH]; // [RL22]
    end
  end
  // zero interval would request every cycle, so it requests nothing
  assign rfsh_hit = rfsh_enable_r && (rfsh_interval_r != 9'h000) &&
                    (rfsh_cnt_r == rfsh_interval_r); // [RL23]
  always_ff @(posedge clock) begin
    if (!resetn || !rfsh_enable_r || rfsh_hit) begin
      rfsh_cnt_r <= 9'h000; // [RL19] [RL23]
    end else begin
      rfsh_cnt_r <= rfsh_cnt_r + 9'h001; // [RL23]
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rfsh_req_r <= 1'b0;
    end else begin
      rfsh_req_r <= rfsh_hit; // [RL23]
    end
  end
  // row advances per request and survives disable
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rfsh_row_r <= '0;
    end else if (rfsh_hit) begin
      rfsh_row_r <= rfsh_row_r + 13'h0001; // [RL19]
    end
  end
  assign refresh_strobe_mode = rfsh_enable_r; // [RL19]
  assign refresh_request = rfsh_req_r;
  assign refresh_address = {rfsh_base_r, rfsh_row_r}; // [RL22]

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          OFS_REFRESH_BASE: rdata_r <= {rfsh_base_r, 9'h000}; // [RL22]
          OFS_REFRESH_INTERVAL: rdata_r <= {7'h00, rfsh_interval_r}; // [RL21]
          OFS_REFRESH_CONTROL:
            rdata_r <= {rfsh_enable_r, 6'h00, rfsh_cnt_r}; // [RL20]
          OFS_WATCHDOG_CONTROL: rdata_r <= wdt_r & WDT_READ_MASK;
          OFS_SYSTEM_CONFIG: rdata_r <= sys_r;
          OFS_AUX_CONFIG: rdata_r <= aux_r;
          OFS_RELEASE_LEVEL: rdata_r <= {RELEASE_CODE, 8'h00}; // [RL2]
          OFS_RESET_LATCH: rdata_r <= latched_pin_value_r; // [RL1]
          default: rdata_r <= 16'h0000;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

endmodule

`default_nettype wire

/* File: sysconf_regs_props.sv */
// assertions on the ports of the configuration register bank
// assumes one clock domain and the bind below onto sysconf_regs
`timescale 1ns/1ps
`default_nettype none
module sysconf_regs_props
  import sysconf_pkg::*;
(
  // clock and register port
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic hw_interrupt,
  // configuration outputs
  input wire logic port1_cts_select,
  input wire logic port1_ready_select,
  input wire logic port0_cts_select,
  input wire logic port0_ready_select,
  input wire logic lower_space_byte_width,
  input wire logic middle_space_byte_width,
  input wire logic io_space_byte_width,
  input wire logic power_save_enable,
  input wire logic [2:0] clock_divider_field,
  input wire logic internal_clock_tick,
  input wire logic clock_out_a_source,
  input wire logic clock_out_a_disable,
  input wire logic clock_out_b_source,
  input wire logic clock_out_b_disable,
  input wire logic whole_range_middle_select,
  input wire logic strobe_select,
  input wire logic demodulator_enable,
  // events
  input wire logic watchdog_reset,
  input wire logic watchdog_nmi,
  input wire logic refresh_strobe_mode,
  input wire logic refresh_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_read;
    reg_rd ##1 reg_rvalid;
  endsequence
  sequence s_rfsh_off;
    !refresh_strobe_mode [*2];
  endsequence

  AST_READ_ANSWER: assert property (reg_rd |-> s_read)
    else $error("read not answered next cycle");
  AST_NO_EXTRA: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without request");
  AST_RELEASE_LOW: assert property (
    reg_rd && reg_addr == OFS_RELEASE_LEVEL |=> reg_rdata[7:0] == 8'h00)
    else $error("release level low byte not zero");
  AST_AUX_WRITE: assert property (
    reg_wr && reg_addr == OFS_AUX_CONFIG |=>
    {port1_cts_select, port1_ready_select, port0_cts_select,
     port0_ready_select, lower_space_byte_width, middle_space_byte_width,
     io_space_byte_width} == $past(reg_wdata[6:0]))
    else $error("aux outputs do not follow write");
  AST_SYS_WRITE: assert property (
    reg_wr && reg_addr == OFS_SYSTEM_CONFIG |=>
    {whole_range_middle_select, strobe_select, demodulator_enable,
     clock_out_b_source, clock_out_b_disable, clock_out_a_source,
     clock_out_a_disable} == $past(reg_wdata[14:8]) &&
    clock_divider_field == $past(reg_wdata[2:0]))
    else $error("system outputs do not follow write");
  AST_HW_CLEAR: assert property (hw_interrupt |=> !power_save_enable)
    else $error("hardware interrupt left power save set");
  AST_SW_KEEP: assert property (
    power_save_enable && !hw_interrupt && !reg_wr |=> power_save_enable)
    else $error("power save dropped without cause");
  AST_TICK_FULL: assert property (
    $past(resetn) && !$past(power_save_enable) |-> internal_clock_tick)
    else $error("clock divided while power save off");
  AST_WDT_RST_PULSE: assert property (
    watchdog_reset |-> !watchdog_nmi ##1 !watchdog_reset)
    else $error("watchdog reset pulse malformed");
  AST_WDT_NMI_PULSE: assert property (watchdog_nmi |=> !watchdog_nmi)
    else $error("watchdog nmi pulse longer than one cycle");
  AST_WDT_STOP: assert property (
    // a timeout already due at the write still fires once
    reg_wr && reg_addr == OFS_WATCHDOG_CONTROL && !reg_wdata[15] |=> ##1
    (!watchdog_reset && !watchdog_nmi) [*8])
    else $error("stopped watchdog timed out");
  AST_RFSH_IDLE: assert property (s_rfsh_off |-> !refresh_request)
    else $error("refresh request while disabled");
  AST_RFSH_ONCE: assert property (
    refresh_request |=> !refresh_request)
    else $error("refresh request longer than one cycle");
  AST_RFSH_MODE: assert property (
    reg_wr && reg_addr == OFS_REFRESH_CONTROL |=>
    refresh_strobe_mode == $past(reg_wdata[15]))
    else $error("refresh strobe mode does not follow enable");
endmodule

bind sysconf_regs sysconf_regs_props i_props (.*);
`default_nettype wire

/* File: test_sysconf_regs.sv */
// self-checking bench for the configuration register bank
// assumes the package and checker are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module test_sysconf_regs
  import sysconf_pkg::*;
;
  // arbitrary release code
  localparam logic [7:0] REL = 8'h5A;
  logic clock, resetn, reg_wr, reg_rd, reg_rvalid;
  logic hw_interrupt, sw_interrupt, interrupt_return;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, ad_pins, pins_seen, v;
  logic port1_cts_select, port1_ready_select, port0_cts_select;
  logic port0_ready_select, lower_space_byte_width;
  logic middle_space_byte_width, io_space_byte_width, power_save_enable;
  logic [2:0] clock_divider_field;
  logic internal_clock_tick, clock_out_a_source, clock_out_a_disable;
  logic clock_out_b_source, clock_out_b_disable, strobe_select;
  logic whole_range_middle_select, demodulator_enable, watchdog_reset;
  logic watchdog_nmi, refresh_strobe_mode, refresh_request;
  logic [19:0] refresh_address, addr_keep;
  logic [31:0] seed, ent;
  logic [31:0] exp_q[$];
  int err_total, compares, n;

  sysconf_regs #(.TIMEOUT_EXP_REDUCE(14), .RELEASE_CODE(REL)) i_dut (.*);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  // answer checked by the monitor; mask hides moving fields
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input logic [15:0] m = 16'hFFFF);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back({m, e & m});
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic count(input int cyc, input bit rf, output int k);
    k = 0;
    repeat (cyc) begin
      @(posedge clock);
      if ((rf ? refresh_request : internal_clock_tick) === 1'b1) k++;
    end
  endtask

  task automatic wdt(input logic [15:0] d, input logic rst, input int cyc);
    int k;
    wr(8'hE6, d);
    k = 0;
    while (watchdog_reset !== 1'b1 && watchdog_nmi !== 1'b1 && k < 9000) begin
      @(posedge clock);
      #1;
      k++;
    end
    check(16'(k), 16'(cyc));
    check({15'h0, watchdog_reset}, {15'h0, rst});
  endtask

  task automatic end_sim;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("FAIL t=%0t unexpected read answer", $time);
      end else begin
        ent = exp_q.pop_front();
        check(reg_rdata & ent[31:16], ent[15:0]);
      end
    end
  end

  // hang guard, well beyond the expected run
  initial begin
    #1500000;
    err_total++;
    end_sim();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h2911;
    err_total = 0;
    compares = 0;
    {reg_wr, reg_rd, hw_interrupt, sw_interrupt, interrupt_return} = '0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    ad_pins = 16'($random(seed));
    resetn = 1'b0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    pins_seen = ad_pins;
    @(posedge clock);
    ad_pins <= ~pins_seen;
    rd(8'hE6, 16'hC080);
    wr(8'hE6, 16'h0000);
    rd(8'hE0, 16'h0000);
    rd(8'hE4, 16'h0000);
    rd(8'hF0, 16'h0000);
    rd(8'hF2, 16'h0000);
    rd(8'hE8, 16'h0000);
    wr(8'hF6, ~pins_seen);
    wr(8'hF4, 16'hFFFF);
    rd(8'hF6, pins_seen);
    rd(8'hF4, {REL, 8'h00});
    repeat (4) begin
      v = 16'($random(seed));
      wr(8'hF2, v);
      check({9'h0, port1_cts_select,
        port1_ready_select, port0_cts_select, port0_ready_select,
        lower_space_byte_width, middle_space_byte_width,
        io_space_byte_width}, v & 16'h007F);
      rd(8'hF2, v & 16'h007F);
      v = 16'($random(seed)) & 16'h7FFF;
      wr(8'hF0, v);
      check({1'b0, whole_range_middle_select,
        strobe_select, demodulator_enable, clock_out_b_source,
        clock_out_b_disable, clock_out_a_source, clock_out_a_disable,
        5'h00, clock_divider_field}, v & 16'hFF07);
      rd(8'hF0, v & 16'hFF07);
    end
    for (int k = 0; k < 8; k++) begin
      wr(8'hF0, 16'h8000 | 16'(k));
      repeat (130) @(posedge clock);
      count(256, 1'b0, n);
      check(16'(n), 16'(256 >> k));
    end
    @(posedge clock);
    {sw_interrupt, interrupt_return} <= 2'b11;
    @(posedge clock);
    {sw_interrupt, interrupt_return} <= 2'b00;
    rd(8'hF0, 16'h8007);
    @(posedge clock);
    hw_interrupt <= 1'b1;
    @(posedge clock);
    hw_interrupt <= 1'b0;
    rd(8'hF0, 16'h0007);
    count(16, 1'b0, n);
    check(16'(n), 16'd16);
    wdt(16'h8002, 1'b0, 64);
    rd(8'hE6, 16'h9002);
    wdt(16'h9002, 1'b1, 64);
    rd(8'hE6, 16'hB002);
    for (int b = 1; b < 8; b++) begin
      v = 16'hC000 | ((16'h00FF << b) & 16'h00FF);
      wdt(v, 1'b1, 1 << (b + 5));
      rd(8'hE6, v | 16'h2000);
    end
    wr(8'hE6, 16'h0000);
    rd(8'hE6, 16'h0000);
    v = 16'($random(seed));
    wr(8'hE0, v);
    rd(8'hE0, v & 16'hFE00);
    wr(8'hE2, 16'hFFFF);
    rd(8'hE2, 16'h01FF);
    wr(8'hE2, 16'h0003);
    wr(8'hE4, 16'hFFFF);
    rd(8'hE4, 16'h8000, 16'hFE00);
    count(40, 1'b1, n);
    check(16'(n), 16'd10);
    check({9'h0, refresh_address[19:13]}, {9'h0, v[15:9]});
    check({15'h0, refresh_strobe_mode}, 16'h0001);
    wr(8'hE4, 16'h0000);
    addr_keep = refresh_address;
    rd(8'hE4, 16'h0000);
    count(20, 1'b1, n);
    check(16'(n), 16'd0);
    check(refresh_address[15:0], addr_keep[15:0]);
    end_sim();
  end
endmodule
`default_nettype wire
